// ===== hdl/sqf_device.sv
// Device end: command framing, check codes, write and read of the
// 512-byte sequencer memory. Assumes the host keeps the frame order.
//
// Overview of operation
// - Host sends 66h, length, command, parameters
// - Device returns inverted check over request
// - Host sends release byte AAh after check
// - Device starts only on release byte AAh
// - Host holds pullup power for operation delay
// - Dummy byte precedes response, excluded from check
// - Response: length, result, data, inverted check
// - Unsupported command answers length 00h, FFFFh
// - Write code 11h: address low, high, data
// - Address nine bits; bit 0 of byte two
// - Write length 4..131, data count length minus three
// - Write overrun past 512 writes nothing, 77h
// - Write data stored consecutively in arrival order
// - Bytes buffered first, copied during execution
// - Write response length one plus check
// - Result AAh success, 77h invalid parameter
// - Read code 22h, length three, two parameters
// - Count bits 7:1, zero means 128
// - Read overrun past 512 rejected with 77h
// - Valid read returns memory bytes after result
`timescale 1ns/1ps
module sqf_device
  import sqf_pkg::*;
(
  input wire logic CLOCK_IN, // 20 MHz clock
  input wire logic RSTN_IN, // Async reset, active low
  sqf_link_if.device LINK, // Link to host
  output logic BUSY_OUT // High while a command executes
);
  import sqf_pkg::*;

  // ==========================================================
  // State machine
  typedef enum logic [3:0] {
    SQF_D_IDLE = 4'h0, SQF_D_START = 4'h1, SQF_D_LEN = 4'h3,
    SQF_D_CMD = 4'h2, SQF_D_PARM = 4'h6, SQF_D_CRC = 4'h7,
    SQF_D_REL = 4'h5, SQF_D_EXEC = 4'h4, SQF_D_DUMMY = 4'hC,
    SQF_D_RESP = 4'hD, SQF_D_DONE = 4'hF
  } sqf_dev_state_type;

  sqf_dev_state_type state_reg;
  logic [15:0] crc_reg;
  logic [7:0] len_reg;
  logic [7:0] cmd_reg;
  logic [7:0] cnt_reg;
  logic [7:0] copy_reg;
  logic [7:0] resp_len_reg;
  logic [7:0] result_reg;
  logic ok_reg;
  logic rd_valid_reg;
  logic [7:0] rd_byte_reg;
  logic [7:0] buf_mem [0:SQF_BUF_DEPTH-1];
  logic [7:0] sram_mem [0:SQF_SRAM_DEPTH-1];

  // ==========================================================
  // Parameter decode from the command buffer
  logic [8:0] addr;
  logic [7:0] wr_count;
  logic [7:0] rd_count;
  logic wr_ok;
  logic rd_ok;
  logic [8:0] rd_addr;
  logic [7:0] resp_byte;
  logic [7:0] crc_lo_idx;

  assign addr = {buf_mem[1][0], buf_mem[0]};
  assign wr_count = len_reg - SQF_WR_OVERHEAD;
  assign rd_count = (buf_mem[1][7:1] == 7'h00) ? SQF_RD_MAX
                    : {1'b0, buf_mem[1][7:1]};
  // Wide sum so an overrun cannot wrap below the limit
  assign wr_ok = (len_reg >= SQF_WR_LEN_MIN) &&
                 (len_reg <= SQF_WR_LEN_MAX) &&
                 ({1'b0, addr} + {2'b00, wr_count} <= SQF_SRAM_LIMIT);
  assign rd_ok = (len_reg == SQF_RD_LEN) &&
                 ({1'b0, addr} + {2'b00, rd_count} <= SQF_SRAM_LIMIT);
  assign rd_addr = addr + {1'b0, cnt_reg} - 9'h002;
  assign crc_lo_idx = resp_len_reg + 8'h01;

  // Response byte by index: length, result, data, check
  always_comb begin
    if (cnt_reg == 8'h00) begin
      resp_byte = resp_len_reg;
    end else if (cnt_reg == 8'h01 && resp_len_reg != 8'h00) begin
      resp_byte = result_reg;
    end else if (cnt_reg <= resp_len_reg) begin
      resp_byte = sram_mem[rd_addr];
    end else if (cnt_reg == crc_lo_idx) begin
      resp_byte = ~crc_reg[7:0];
    end else begin
      resp_byte = ~crc_reg[15:8];
    end
  end

  // ==========================================================
  // Frame sequencing; bus reset wins over everything but the async reset
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg <= SQF_D_IDLE;
      cnt_reg <= 8'h00;
      copy_reg <= 8'h00;
      len_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end else if (LINK.bus_reset) begin
      state_reg <= SQF_D_IDLE;
    end else begin
      unique case (state_reg)
        SQF_D_IDLE: begin
          if (LINK.select) begin
            state_reg <= SQF_D_START;
          end
        end
        SQF_D_START: begin
          if (LINK.wr_valid) begin
            // Anything but the start byte drops the frame
            state_reg <= (LINK.wr_byte == SQF_START_BYTE) ? SQF_D_LEN
                         : SQF_D_IDLE;
          end
        end
        SQF_D_LEN: begin
          if (LINK.wr_valid) begin
            len_reg <= LINK.wr_byte;
            cmd_reg <= 8'h00;
            cnt_reg <= 8'h00;
            state_reg <= (LINK.wr_byte == 8'h00) ? SQF_D_CRC : SQF_D_CMD;
          end
        end
        SQF_D_CMD: begin
          if (LINK.wr_valid) begin
            cmd_reg <= LINK.wr_byte;
            state_reg <= (len_reg == 8'h01) ? SQF_D_CRC : SQF_D_PARM;
          end
        end
        SQF_D_PARM: begin
          if (LINK.wr_valid) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == len_reg - 8'h02) begin
              cnt_reg <= 8'h00;
              state_reg <= SQF_D_CRC;
            end
          end
        end
        SQF_D_CRC: begin
          if (LINK.rd_req) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == 8'h01) begin
              state_reg <= SQF_D_REL;
            end
          end
        end
        SQF_D_REL: begin
          if (LINK.wr_valid) begin
            copy_reg <= 8'h00;
            state_reg <= (LINK.wr_byte == SQF_RELEASE_BYTE) ? SQF_D_EXEC
                         : SQF_D_IDLE;
          end
        end
        SQF_D_EXEC: begin
          // Copy takes at most 128 cycles, well inside the power delay
          if (ok_reg && cmd_reg == SQF_CMD_WRITE &&
              copy_reg != wr_count - 8'h01) begin
            copy_reg <= copy_reg + 8'h01;
          end else begin
            state_reg <= SQF_D_DUMMY;
          end
        end
        SQF_D_DUMMY: begin
          if (LINK.rd_req) begin
            cnt_reg <= 8'h00;
            state_reg <= SQF_D_RESP;
          end
        end
        SQF_D_RESP: begin
          if (LINK.rd_req) begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == crc_lo_idx + 8'h01) begin
              state_reg <= SQF_D_DONE;
            end
          end
        end
        SQF_D_DONE: begin
          state_reg <= SQF_D_DONE;
        end
        default: begin
          state_reg <= SQF_D_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Command buffer; data lands here before touching memory
  always_ff @(posedge CLOCK_IN) begin
    if (state_reg == SQF_D_PARM && LINK.wr_valid &&
        cnt_reg < SQF_BUF_DEPTH[7:0]) begin
      buf_mem[cnt_reg] <= LINK.wr_byte;
    end
  end

  // Sequencer memory, written only after a validated release
  always_ff @(posedge CLOCK_IN) begin
    if (state_reg == SQF_D_EXEC && ok_reg && cmd_reg == SQF_CMD_WRITE) begin
      sram_mem[addr + {1'b0, copy_reg}] <=
        buf_mem[copy_reg + SQF_BUF_DATA_OFS];
    end
  end

  // ==========================================================
  // Validation and result on release
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ok_reg <= 1'b0;
      result_reg <= SQF_RES_BAD;
      resp_len_reg <= 8'h00;
    end else if (state_reg == SQF_D_REL && LINK.wr_valid) begin
      if (cmd_reg == SQF_CMD_WRITE) begin
        ok_reg <= wr_ok;
        result_reg <= wr_ok ? SQF_RES_OK : SQF_RES_BAD;
        resp_len_reg <= 8'h01;
      end else if (cmd_reg == SQF_CMD_READ) begin
        ok_reg <= rd_ok;
        result_reg <= rd_ok ? SQF_RES_OK : SQF_RES_BAD;
        resp_len_reg <= rd_ok ? rd_count + 8'h01 : 8'h01;
      end else begin
        ok_reg <= 1'b0;
        result_reg <= SQF_RES_BAD;
        resp_len_reg <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Running check: request from start byte, response from length
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      crc_reg <= SQF_CRC_INIT;
    end else if (state_reg == SQF_D_START) begin
      crc_reg <= sqf_crc_byte(SQF_CRC_INIT, SQF_START_BYTE);
    end else if (LINK.wr_valid && (state_reg == SQF_D_LEN ||
             state_reg == SQF_D_CMD || state_reg == SQF_D_PARM)) begin
      crc_reg <= sqf_crc_byte(crc_reg, LINK.wr_byte);
    end else if (state_reg == SQF_D_EXEC) begin
      crc_reg <= SQF_CRC_INIT; // Dummy never enters
    end else if (state_reg == SQF_D_RESP && LINK.rd_req &&
                 cnt_reg <= resp_len_reg) begin
      crc_reg <= sqf_crc_byte(crc_reg, resp_byte);
    end
  end

  // ==========================================================
  // Read slot answer, one cycle after each request
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_valid_reg <= 1'b0;
      rd_byte_reg <= SQF_IDLE_BYTE;
    end else begin
      rd_valid_reg <= LINK.rd_req;
      if (LINK.rd_req) begin
        unique case (state_reg)
          SQF_D_CRC: rd_byte_reg <= (cnt_reg == 8'h00) ? ~crc_reg[7:0]
                                    : ~crc_reg[15:8];
          SQF_D_DUMMY: rd_byte_reg <= SQF_DUMMY_BYTE;
          SQF_D_RESP: rd_byte_reg <= resp_byte;
          default: rd_byte_reg <= SQF_IDLE_BYTE;
        endcase
      end
    end
  end

  assign LINK.rd_valid = rd_valid_reg;
  assign LINK.rd_byte = rd_byte_reg;
  assign BUSY_OUT = (state_reg == SQF_D_EXEC);

endmodule : sqf_device

// ===== hdl/sqf_host.sv
// Host end: issues one framed command per START_IN pulse and
// returns the response. Assumes the device answers reads next cycle.
`timescale 1ns/1ps
module sqf_host
  import sqf_pkg::*;
(
  input wire logic CLOCK_IN, // 20 MHz clock
  input wire logic RSTN_IN, // Async reset, active low
  sqf_link_if.host LINK, // Link to device
  input wire logic START_IN, // Pulse: begin a command
  input wire logic [7:0] CMD_IN, // Function command code
  input wire logic [8:0] ADDR_IN, // Memory start address
  input wire logic [7:0] COUNT_IN, // Byte count, 1..128
  input wire logic [7:0] WDATA_IN, // Write data, held by user
  output logic WDATA_TAKE_OUT, // WDATA_IN consumed this cycle
  output logic [7:0] RDATA_OUT, // Response data byte
  output logic RDATA_VALID_OUT, // Pulse: RDATA_OUT new
  output logic [7:0] RESULT_OUT, // Result byte
  output logic [7:0] RESP_LEN_OUT, // Response length byte
  output logic CRC_ERR_OUT, // Check mismatch this command
  output logic BUSY_OUT, // Command in progress
  output logic DONE_OUT // Pulse: command finished
);
  import sqf_pkg::*;

  // ==========================================================
  // State machine
  typedef enum logic [2:0] {
    SQF_H_IDLE = 3'h0, SQF_H_RST = 3'h1, SQF_H_SEL = 3'h3,
    SQF_H_TX = 3'h2, SQF_H_CRC = 3'h6, SQF_H_SPU = 3'h7,
    SQF_H_RX = 3'h5, SQF_H_END = 3'h4
  } sqf_host_state_type;

  sqf_host_state_type state_reg;
  logic [7:0] idx_reg;
  logic [7:0] len_reg;
  logic [15:0] crc_reg;
  logic [7:0] lo_reg;
  logic [15:0] wait_reg;
  logic wr_valid_reg;
  logic [7:0] wr_byte_reg;
  logic [7:0] tx_byte;
  logic [15:0] rx_crc;

  assign rx_crc = ~{LINK.rd_byte, lo_reg};

  // Request byte by index: start, length, command, parameters, data
  always_comb begin
    WDATA_TAKE_OUT = 1'b0;
    unique case (idx_reg)
      8'h00: tx_byte = SQF_START_BYTE;
      8'h01: tx_byte = len_reg;
      8'h02: tx_byte = CMD_IN;
      8'h03: tx_byte = ADDR_IN[7:0];
      8'h04: tx_byte = (CMD_IN == SQF_CMD_READ)
                       ? {COUNT_IN[6:0], ADDR_IN[8]}
                       : {7'h00, ADDR_IN[8]};
      default: begin
        tx_byte = WDATA_IN;
        WDATA_TAKE_OUT = (state_reg == SQF_H_TX);
      end
    endcase
  end

  // ==========================================================
  // Sequencing of one command frame
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg <= SQF_H_IDLE;
      idx_reg <= 8'h00;
      len_reg <= 8'h00;
      crc_reg <= SQF_CRC_INIT;
      lo_reg <= 8'h00;
      wait_reg <= 16'h0000;
      wr_valid_reg <= 1'b0;
      wr_byte_reg <= 8'h00;
      RDATA_OUT <= 8'h00;
      RDATA_VALID_OUT <= 1'b0;
      RESULT_OUT <= 8'h00;
      RESP_LEN_OUT <= 8'h00;
      CRC_ERR_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
    end else begin
      wr_valid_reg <= 1'b0;
      RDATA_VALID_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      unique case (state_reg)
        SQF_H_IDLE: begin
          if (START_IN) begin
            CRC_ERR_OUT <= 1'b0;
            len_reg <= (CMD_IN == SQF_CMD_WRITE)
                       ? COUNT_IN + SQF_WR_OVERHEAD
                       : (CMD_IN == SQF_CMD_READ) ? SQF_RD_LEN : 8'h01;
            state_reg <= SQF_H_RST;
          end
        end
        SQF_H_RST: state_reg <= SQF_H_SEL;
        SQF_H_SEL: begin
          idx_reg <= 8'h00;
          crc_reg <= SQF_CRC_INIT;
          state_reg <= SQF_H_TX;
        end
        SQF_H_TX: begin
          wr_valid_reg <= 1'b1;
          wr_byte_reg <= tx_byte;
          crc_reg <= sqf_crc_byte(crc_reg, tx_byte);
          idx_reg <= idx_reg + 8'h01;
          if (idx_reg == len_reg + 8'h01) begin
            idx_reg <= 8'h00;
            state_reg <= SQF_H_CRC;
          end
        end
        SQF_H_CRC: begin
          if (LINK.rd_valid) begin
            idx_reg <= idx_reg + 8'h01;
            lo_reg <= LINK.rd_byte;
            if (idx_reg == 8'h01) begin
              // Release only on a good check, else drop the frame
              if (rx_crc == crc_reg) begin
                wr_valid_reg <= 1'b1;
                wr_byte_reg <= SQF_RELEASE_BYTE;
                wait_reg <= 16'h0000;
                state_reg <= SQF_H_SPU;
              end else begin
                CRC_ERR_OUT <= 1'b1;
                state_reg <= SQF_H_END;
              end
            end
          end
        end
        SQF_H_SPU: begin
          // Power counts only once the release byte has left the wire
          if (!wr_valid_reg) begin
            wait_reg <= wait_reg + 16'h0001;
            if (wait_reg == 16'(SQF_OP_CYCLES - 1)) begin
              idx_reg <= 8'h00;
              crc_reg <= SQF_CRC_INIT;
              state_reg <= SQF_H_RX;
            end
          end
        end
        SQF_H_RX: begin
          if (LINK.rd_valid) begin
            idx_reg <= idx_reg + 8'h01;
            lo_reg <= LINK.rd_byte;
            if (idx_reg != 8'h00 && idx_reg <= RESP_LEN_OUT + 8'h01) begin
              crc_reg <= sqf_crc_byte(crc_reg, LINK.rd_byte);
            end
            if (idx_reg == 8'h01) begin
              RESP_LEN_OUT <= LINK.rd_byte;
            end else if (idx_reg == 8'h02 && RESP_LEN_OUT != 8'h00) begin
              RESULT_OUT <= LINK.rd_byte;
            end else if (idx_reg > 8'h02 &&
                         idx_reg <= RESP_LEN_OUT + 8'h01) begin
              RDATA_OUT <= LINK.rd_byte;
              RDATA_VALID_OUT <= 1'b1;
            end else if (idx_reg == RESP_LEN_OUT + 8'h03) begin
              CRC_ERR_OUT <= (rx_crc != crc_reg);
              state_reg <= SQF_H_END;
            end
          end
        end
        SQF_H_END: begin
          DONE_OUT <= 1'b1;
          state_reg <= SQF_H_IDLE;
        end
        default: state_reg <= SQF_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Link drives; no read slot beside a write byte, else the device
  // would answer it before taking the last request byte
  assign LINK.bus_reset = (state_reg == SQF_H_RST);
  assign LINK.select = (state_reg == SQF_H_SEL);
  assign LINK.wr_valid = wr_valid_reg;
  assign LINK.wr_byte = wr_byte_reg;
  assign LINK.rd_req = (state_reg == SQF_H_CRC || state_reg == SQF_H_RX)
                       && !LINK.rd_valid && !wr_valid_reg;
  assign LINK.spu = (state_reg == SQF_H_SPU) && !wr_valid_reg;
  assign BUSY_OUT = (state_reg != SQF_H_IDLE);

endmodule : sqf_host

// ===== hdl/sqf_link_if.sv
// Byte-level model of the single-wire link between host and device.
// Assumes both ends share one clock; bit timing is abstracted away.
`timescale 1ns/1ps
interface sqf_link_if;
  logic bus_reset; // Host: bus reset pulse, aborts any frame
  logic select; // Host: pulse, device selection complete
  logic wr_valid; // Host: one-cycle byte write
  logic [7:0] wr_byte; // Host: byte written
  logic rd_req; // Host: one-cycle read slot request
  logic rd_valid; // Device: answer, one cycle after rd_req
  logic [7:0] rd_byte; // Device: byte read
  logic spu; // Host: strong pullup power level

  modport device (input bus_reset, select, wr_valid, wr_byte, rd_req, spu,
                  output rd_valid, rd_byte);
  modport host (output bus_reset, select, wr_valid, wr_byte, rd_req, spu,
                input rd_valid, rd_byte);
endinterface : sqf_link_if

// ===== hdl/sqf_pkg.sv
// Shared constants for the sequencer memory command front end.
// Assumes both ends run on one 20 MHz clock and meet in sqf_link_if.
package sqf_pkg;

  // ==========================================================
  // Frame bytes and codes
  localparam logic [7:0] SQF_START_BYTE = 8'h66;
  localparam logic [7:0] SQF_RELEASE_BYTE = 8'hAA;
  localparam logic [7:0] SQF_CMD_WRITE = 8'h11;
  localparam logic [7:0] SQF_CMD_READ = 8'h22;
  localparam logic [7:0] SQF_RES_OK = 8'hAA;
  localparam logic [7:0] SQF_RES_BAD = 8'h77;
  localparam logic [7:0] SQF_DUMMY_BYTE = 8'hFF;
  localparam logic [7:0] SQF_IDLE_BYTE = 8'hFF;

  // ==========================================================
  // Lengths and sizes
  localparam int SQF_SRAM_DEPTH = 512;
  localparam int SQF_BUF_DEPTH = 130;
  localparam logic [9:0] SQF_SRAM_LIMIT = 10'h200;
  localparam logic [7:0] SQF_WR_LEN_MIN = 8'h04;
  localparam logic [7:0] SQF_WR_LEN_MAX = 8'h83;
  localparam logic [7:0] SQF_WR_OVERHEAD = 8'h03;
  localparam logic [7:0] SQF_RD_LEN = 8'h03;
  localparam logic [7:0] SQF_RD_MAX = 8'h80;
  localparam logic [7:0] SQF_BUF_DATA_OFS = 8'h02;

  // ==========================================================
  // Check code
  localparam logic [15:0] SQF_CRC_INIT = 16'h0000;
  localparam logic [15:0] SQF_CRC_POLY_REV = 16'hA001;

  // ==========================================================
  // Timing: operation delay, host holds power this long
  localparam int SQF_CLK_MHZ = 20;
  localparam int SQF_T_OP_US = 100;
  localparam int SQF_OP_CYCLES = SQF_T_OP_US * SQF_CLK_MHZ;

  // One byte into the reflected x16+x15+x2+1 check, LSB first
  function automatic logic [15:0] sqf_crc_byte(input logic [15:0] crc,
                                               input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ SQF_CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction : sqf_crc_byte

endpackage : sqf_pkg

// ===== tb/sqf_link_props.sv
// Checker for the byte-level link between host and device ends.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
module sqf_link_props (
  input wire logic CLOCK_IN, // Clock
  input wire logic RSTN_IN, // Reset, active low
  input wire logic bus_reset, // Frame abort
  input wire logic select, // Selection done
  input wire logic wr_valid, // Host byte strobe
  input wire logic [7:0] wr_byte, // Host byte
  input wire logic rd_req, // Read slot request
  input wire logic rd_valid, // Device answer strobe
  input wire logic [7:0] rd_byte, // Device byte
  input wire logic spu // Pullup power
);
  import sqf_pkg::*;
  // ==========================================================
  // Helper state
  logic start_due_reg;
  logic dummy_due_reg;
  logic [11:0] spu_cnt_reg;
  // Start byte is due from selection until the first write
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) start_due_reg <= 1'b0;
    else if (select) start_due_reg <= 1'b1;
    else if (wr_valid) start_due_reg <= 1'b0;
  end
  // Dummy is due from power until the first answer
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) dummy_due_reg <= 1'b0;
    else if (spu) dummy_due_reg <= 1'b1;
    else if (rd_valid) dummy_due_reg <= 1'b0;
  end
  // Length of the power phase; 12 bits hold the delay
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) spu_cnt_reg <= 12'h000;
    else spu_cnt_reg <= spu ? spu_cnt_reg + 12'h001 : 12'h000;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_release;
    wr_valid && wr_byte == SQF_RELEASE_BYTE;
  endsequence
  sequence s_answer;
    ##1 rd_valid;
  endsequence
  a_rd_answer: assert property (rd_req |-> s_answer)
    else $error("read slot not answered");
  a_rd_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("answer without read slot");
  a_rd_hold: assert property (!rd_valid |-> $stable(rd_byte))
    else $error("read byte changed without answer");
  a_start_byte: assert property (start_due_reg && wr_valid |->
    wr_byte == SQF_START_BYTE) else $error("first byte not start");
  a_sel_frame: assert property (select |-> ##[1:4] wr_valid)
    else $error("no frame after selection");
  a_power_on: assert property (s_release |-> ##[0:2] spu)
    else $error("no power after release");
  a_power_len: assert property ($fell(spu) |->
    spu_cnt_reg >= 12'(SQF_OP_CYCLES)) else $error("power too short");
  a_quiet_power: assert property (spu |-> !rd_req && !wr_valid)
    else $error("traffic during power");
  a_dummy_ff: assert property (rd_valid && dummy_due_reg |->
    rd_byte == SQF_DUMMY_BYTE) else $error("bad dummy byte");
endmodule : sqf_link_props

// ===== tb/sqf_tb.sv
// Bench: host and device ends joined by the link, rows of commands.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ps
module sqf_tb;
  import sqf_pkg::*;
  // ==========================================================
  // Signals, reference memory, captured traffic
  typedef struct packed {
    logic [7:0] c;
    logic [8:0] a;
    logic [7:0] n;
    logic [7:0] r;
    logic [7:0] l;
  } sqf_row_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hrstn = 1'b1;
  logic start = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [8:0] addr = 9'h000;
  logic [7:0] cnt = 8'h01;
  logic [7:0] widx = 8'h00;
  logic [7:0] salt = 8'h00;
  logic take, rvalid, hbusy, done, crc_err, dbusy;
  logic [7:0] rdata, res, rlen;
  logic [7:0] mem [512];
  logic [7:0] wq[$], rq[$], dq[$];
  int n_errors = 0;
  int tests_run = 0;
  sqf_row_type rows [10] = '{
    '{8'h11, 9'h000, 8'h01, 8'hAA, 8'h01},
    '{8'h11, 9'h1FF, 8'h01, 8'hAA, 8'h01},
    '{8'h11, 9'h180, 8'h80, 8'hAA, 8'h01},
    '{8'h11, 9'h1F0, 8'h11, 8'h77, 8'h01},
    '{8'h11, 9'h0FE, 8'h05, 8'hAA, 8'h01},
    '{8'h22, 9'h000, 8'h01, 8'hAA, 8'h02},
    '{8'h22, 9'h180, 8'h80, 8'hAA, 8'h81},
    '{8'h22, 9'h0FE, 8'h05, 8'hAA, 8'h06},
    '{8'h22, 9'h1FF, 8'h02, 8'h77, 8'h01},
    '{8'h33, 9'h000, 8'h01, 8'h00, 8'h00}};
  sqf_link_if link ();
  sqf_device u_sqf_device (.CLOCK_IN(clk), .RSTN_IN(rstn), .LINK(link),
    .BUSY_OUT(dbusy));
  sqf_host u_sqf_host (.CLOCK_IN(clk), .RSTN_IN(rstn & hrstn),
    .LINK(link), .START_IN(start), .CMD_IN(cmd), .ADDR_IN(addr),
    .COUNT_IN(cnt), .WDATA_IN((widx + salt) & 8'h7F),
    .WDATA_TAKE_OUT(take), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid),
    .RESULT_OUT(res), .RESP_LEN_OUT(rlen), .CRC_ERR_OUT(crc_err),
    .BUSY_OUT(hbusy), .DONE_OUT(done));
  sqf_link_props u_sqf_link_props (.CLOCK_IN(clk),
    .RSTN_IN(rstn & hrstn), .bus_reset(link.bus_reset),
    .select(link.select), .wr_valid(link.wr_valid),
    .wr_byte(link.wr_byte), .rd_req(link.rd_req),
    .rd_valid(link.rd_valid), .rd_byte(link.rd_byte), .spu(link.spu));
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  // Capture link bytes and user data; data kept below 80h so it never
  // looks like a release byte
  always @(posedge clk) begin
    if (link.wr_valid === 1'b1) wq.push_back(link.wr_byte);
    if (link.rd_valid === 1'b1) rq.push_back(link.rd_byte);
    if (rvalid === 1'b1) dq.push_back(rdata);
    if (take === 1'b1) widx <= widx + 8'h01;
  end
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Reflected check code, computed bit by bit
  function automatic logic [15:0] crc(input logic [7:0] q[$], int a, n);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = a; i < a + n; i++)
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? 16'hA001 : 16'h0000);
    return c;
  endfunction : crc
  task automatic run(input logic [7:0] c, input logic [8:0] a,
                     input logic [7:0] n, r, l);
    int k;
    int bc;
    wq = {};
    rq = {};
    dq = {};
    cmd = c;
    addr = a;
    cnt = n;
    widx = 8'h00;
    salt = salt + 8'h10;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    check("host busy", {15'h0000, hbusy}, 16'h0001);
    bc = 0;
    for (k = 0; k < 5000 && done !== 1'b1; k++) begin
      @(posedge clk) #1;
      if (dbusy === 1'b1) bc++;
    end
    check("done", {15'h0000, done}, 16'h0001);
    if (done !== 1'b1) finish_test();
    check("dev busy", {15'h0000, bc != 0}, 16'h0001);
    check("crc flag", {15'h0000, crc_err}, 16'h0000);
    check("release", wq[$], SQF_RELEASE_BYTE);
    check("req crc", {rq[1], rq[0]}, ~crc(wq, 0, wq.size() - 1));
    check("dummy", rq[2], SQF_DUMMY_BYTE);
    check("len", rq[3], l);
    check("len out", rlen, l);
    if (l != 8'h00) check("result", res, r);
    check("rsp crc", {rq[5 + l], rq[4 + l]}, ~crc(rq, 3, l + 1));
    if (c == SQF_CMD_READ && r == SQF_RES_OK) begin
      check("count", 16'(dq.size()), 16'(l - 8'h01));
      foreach (dq[i]) check("data", dq[i], mem[a + i]);
    end
    if (c == SQF_CMD_WRITE && r == SQF_RES_OK)
      for (k = 0; k < n; k++) mem[a + k] = (k + salt) & 8'h7F;
  endtask : run
  task automatic finish_test;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // ==========================================================
  // Main sequence: reset, rows, then a frame cut off by host reset
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    check("reset", {5'h00, dbusy, hbusy, done, rlen}, 16'h0000);
    foreach (rows[i])
      run(rows[i].c, rows[i].a, rows[i].n, rows[i].r, rows[i].l);
    cmd = SQF_CMD_WRITE;
    addr = 9'h000;
    cnt = 8'h40;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    repeat (30) @(posedge clk);
    #1 hrstn = 1'b0;
    @(posedge clk) #1 hrstn = 1'b1;
    run(SQF_CMD_READ, 9'h000, 8'h01, SQF_RES_OK, 8'h02);
    finish_test();
  end
endmodule : sqf_tb
